/* File: core/ctp_pkg.sv */
package ctp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // addressing
   localparam logic [6:0] DEV_BASE_ADDR  = 7'h08;
   localparam int unsigned REG_COUNT     = 32;
   localparam int unsigned REG_IDX_W     = 5;
   localparam logic [7:0] REG_RESET_VAL  = 8'h00;
   localparam logic [7:0] REG_CLK_CTRL   = 8'h00;
   localparam int unsigned MCLK_EN_BIT   = 0;
   localparam logic [7:0] REG_ADC_CTRL   = 8'h0F;
   localparam int unsigned ADC_MASTER_BIT = 0;

   ////////////////////////////////////////////////////////////////////////////
   // timing counts
   localparam logic [8:0] INIT_MCLK_CYCLES = 9'h100;
   localparam logic [1:0] STRAP_SETTLE     = 2'h3;
   localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
   localparam logic [3:0] LAST_TX_BIT      = 4'h7;

   ////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic       rd;
      logic [7:0] ptr;
      logic [7:0] data;
   } ctp_req_t;

   typedef struct packed {
      logic pll_locked;
      logic addr_high;
      logic addr_low;
      logic scl;
      logic sda;
   } ctp_strap_in_t;

   typedef struct packed {
      logic ce;
      logic init_done;
      logic addr_high;
      logic addr_low;
      logic scl;
      logic sda;
   } ctp_link_in_t;

   typedef enum logic [7:0] {
      ST_IDLE   = 8'h01,
      ST_ADDR   = 8'h02,
      ST_REG    = 8'h04,
      ST_WDATA  = 8'h08,
      ST_SACK   = 8'h10,
      ST_RDATA  = 8'h20,
      ST_MACK   = 8'h40,
      ST_IGNORE = 8'h80
   } ctp_state_t;

endpackage

/* File: core/ctp_sync.sv */
`timescale 1ns/100ps
module ctp_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,   // destination clock
   input  wire logic         rst_b, // async reset, active low
   input  wire logic         ce,    // clock enable
   input  wire logic [W-1:0] d,     // level from another domain
   output logic      [W-1:0] q      // level safe to use
);

   logic [W-1:0] meta_r;

   // meta_r feeds q and nothing else
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_r <= '0;
         q      <= '0;
      end else if (ce) begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule

/* File: core/ctp_hs.sv */
`timescale 1ns/100ps
module ctp_hs (
   input  wire logic src_clk,   // requesting side clock
   input  wire logic src_rst_b, // async reset, active low
   input  wire logic src_ce,    // clock enable, requesting side
   input  wire logic src_go,    // pulse: start a transfer
   output logic      src_busy,  // transfer in flight
   output logic      src_done,  // pulse: far side has taken it
   input  wire logic dst_clk,   // serving side clock
   input  wire logic dst_rst_b, // async reset, active low
   input  wire logic dst_ce,    // clock enable, serving side
   output logic      dst_take   // pulse: payload stable, use it
);

   logic req_tgl_r;
   logic req_tgl_nxt;
   logic req_s;
   logic req_d_r;
   logic ack_s;
   logic ack_d_r;

   // a go while busy is dropped; the caller must wait
   assign req_tgl_nxt = req_tgl_r ^ (src_go & ~src_busy);
   assign src_busy    = req_tgl_r ^ ack_s;
   assign src_done    = ack_s ^ ack_d_r;
   assign dst_take    = req_s ^ req_d_r;

   always_ff @(posedge src_clk or negedge src_rst_b) begin
      if (!src_rst_b) begin
         req_tgl_r <= 1'b0;
         ack_d_r   <= 1'b0;
      end else if (src_ce) begin
         req_tgl_r <= req_tgl_nxt;
         ack_d_r   <= ack_s;
      end
   end

   // req_d_r doubles as the returning acknowledge toggle
   always_ff @(posedge dst_clk or negedge dst_rst_b) begin
      if (!dst_rst_b) begin
         req_d_r <= 1'b0;
      end else if (dst_ce) begin
         req_d_r <= req_s;
      end
   end

   ctp_sync u_req_sync (
      .clk   (dst_clk),
      .rst_b (dst_rst_b),
      .ce    (dst_ce),
      .d     (req_tgl_r),
      .q     (req_s)
   );

   ctp_sync u_ack_sync (
      .clk   (src_clk),
      .rst_b (src_rst_b),
      .ce    (src_ce),
      .d     (req_d_r),
      .q     (ack_s)
   );

endmodule

/* File: core/ctp_port.sv */
`timescale 1ns/100ps
module ctp_port (
   input  wire logic                      clk,             // core clock
   input  wire logic                      rst_b,           // async reset
   input  wire logic                      ce,              // clock enable
   input  wire logic                      link_clk,        // link clock
   input  wire logic                      scl_i,           // SCL pin level
   input  wire logic                      sda_i,           // SDA pin level
   output logic                           sda_o,           // SDA drive level
   output logic                           sda_oe,          // SDA pulled low
   input  wire logic                      addr_strap_low,  // address strap 0
   input  wire logic                      addr_strap_high, // address strap 1
   input  wire logic                      pll_locked,      // clock gen lock
   output logic                           init_done,       // init complete
   output logic                           standalone,      // strapped mode
   output logic                           mclk_enable,     // master clk on
   output logic                           adc_clk_master,  // ADC clk master
   output logic [ctp_pkg::REG_COUNT-1:0][7:0] ctrl_regs    // register file
);

   ////////////////////////////////////////////////////////////////////////////
   // core domain: strap capture and initialisation

   ctp_pkg::ctp_strap_in_t strap_in;
   ctp_pkg::ctp_strap_in_t strap_s;
   logic [1:0]             settle_cnt_r;
   logic                   strap_done_r;
   logic                   strap_take;
   logic                   stand_load;
   logic                   standalone_r;
   logic [8:0]             init_cnt_r;
   logic                   init_done_r;
   logic                   init_run;

   assign strap_in = {pll_locked, addr_strap_high, addr_strap_low,
                      scl_i, sda_i};

   ctp_sync #(
      .W ($bits(ctp_pkg::ctp_strap_in_t))
   ) u_strap_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .ce    (ce),
      .d     (strap_in),
      .q     (strap_s)
   );

   // capture waits for the synchroniser to fill with real pin levels
   assign strap_take = !strap_done_r &&
                       settle_cnt_r == ctp_pkg::STRAP_SETTLE;
   assign stand_load = strap_take && !strap_s.addr_high &&
                       !strap_s.addr_low && !strap_s.scl;
   assign init_run   = strap_done_r && strap_s.pll_locked && !init_done_r;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         settle_cnt_r <= 2'h0;
         strap_done_r <= 1'b0;
         standalone_r <= 1'b0;
      end else if (ce) begin
         if (!strap_done_r && !strap_take) begin
            settle_cnt_r <= settle_cnt_r + 2'h1;
         end
         if (strap_take) begin
            strap_done_r <= 1'b1;
            standalone_r <= stand_load;
         end
      end
   end

   // counts core clocks as the master clock stand-in
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         init_cnt_r  <= 9'h000;
         init_done_r <= 1'b0;
      end else if (ce && init_run) begin
         init_cnt_r <= init_cnt_r + 9'h001;
         if (init_cnt_r == ctp_pkg::INIT_MCLK_CYCLES - 9'h001) begin
            init_done_r <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // core domain: register file

   logic [ctp_pkg::REG_COUNT-1:0][7:0] reg_r;
   logic [ctp_pkg::REG_COUNT-1:0][7:0] reg_nxt;
   logic [7:0]                         rd_data_r;
   ctp_pkg::ctp_req_t                  req_r;
   logic                               core_take;
   logic                               wr_fire;
   logic                               rd_fire;
   logic                               ptr_in_range;
   logic [ctp_pkg::REG_IDX_W-1:0]      ptr_idx;

   // req_r is held by the link side until the handshake closes
   assign ptr_in_range = req_r.ptr[7:ctp_pkg::REG_IDX_W] == '0;
   assign ptr_idx      = req_r.ptr[ctp_pkg::REG_IDX_W-1:0];
   assign wr_fire      = core_take && !req_r.rd && ptr_in_range;
   assign rd_fire      = core_take && req_r.rd;

   for (genvar i = 0; i < ctp_pkg::REG_COUNT; i++) begin : g_reg
      localparam logic [7:0] IDX = 8'(i);
      logic [7:0] load_val;
      logic       hit;

      assign hit = wr_fire && req_r.ptr == IDX;
      always_comb begin
         load_val = ctp_pkg::REG_RESET_VAL;
         if (IDX == ctp_pkg::REG_CLK_CTRL) begin
            load_val[ctp_pkg::MCLK_EN_BIT] = 1'b1;
         end
         if (IDX == ctp_pkg::REG_ADC_CTRL) begin
            load_val[ctp_pkg::ADC_MASTER_BIT] = strap_s.sda;
         end
      end
      assign reg_nxt[i] = stand_load ? load_val :
                          hit        ? req_r.data : reg_r[i];

      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            reg_r[i] <= ctp_pkg::REG_RESET_VAL;
         end else if (ce) begin
            reg_r[i] <= reg_nxt[i];
         end
      end
   end

   // out-of-range pointers read back as zero and swallow writes
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data_r <= 8'h00;
      end else if (ce && rd_fire) begin
         rd_data_r <= ptr_in_range ? reg_r[ptr_idx] : 8'h00;
      end
   end

   assign ctrl_regs      = reg_r;
   assign init_done      = init_done_r;
   assign standalone     = standalone_r;
   assign mclk_enable    = reg_r[ctp_pkg::REG_CLK_CTRL[ctp_pkg::REG_IDX_W-1:0]]
                                [ctp_pkg::MCLK_EN_BIT];
   assign adc_clk_master = reg_r[ctp_pkg::REG_ADC_CTRL[ctp_pkg::REG_IDX_W-1:0]]
                                [ctp_pkg::ADC_MASTER_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // link domain: pin conditioning and bus events

   ctp_pkg::ctp_link_in_t lk_in;
   ctp_pkg::ctp_link_in_t lk;
   logic                  scl_d_r;
   logic                  sda_d_r;
   logic                  scl_rise;
   logic                  scl_fall;
   logic                  start_ev;
   logic                  stop_ev;
   logic [6:0]            dev_addr;

   assign lk_in = {ce, init_done_r, addr_strap_high, addr_strap_low,
                   scl_i, sda_i};

   ctp_sync #(
      .W ($bits(ctp_pkg::ctp_link_in_t))
   ) u_link_sync (
      .clk   (link_clk),
      .rst_b (rst_b),
      .ce    (1'b1),
      .d     (lk_in),
      .q     (lk)
   );

   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else if (lk.ce) begin
         scl_d_r <= lk.scl;
         sda_d_r <= lk.sda;
      end
   end

   assign scl_rise = lk.scl && !scl_d_r;
   assign scl_fall = !lk.scl && scl_d_r;
   assign start_ev = lk.scl && scl_d_r && sda_d_r && !lk.sda;
   assign stop_ev  = lk.scl && scl_d_r && !sda_d_r && lk.sda;
   assign dev_addr = ctp_pkg::DEV_BASE_ADDR |
                     {5'h00, lk.addr_high, lk.addr_low};

   ////////////////////////////////////////////////////////////////////////////
   // link domain: transaction engine

   ctp_pkg::ctp_state_t st_r;
   ctp_pkg::ctp_state_t st_nxt;
   ctp_pkg::ctp_state_t after_r;
   ctp_pkg::ctp_state_t after_nxt;
   logic [3:0]          cnt_r;
   logic [3:0]          cnt_nxt;
   logic [7:0]          shift_r;
   logic [7:0]          shift_nxt;
   logic [7:0]          tx_r;
   logic [7:0]          tx_nxt;
   logic [7:0]          ptr_r;
   logic [7:0]          ptr_nxt;
   logic [7:0]          rd_buf_r;
   logic                oe_r;
   logic                oe_nxt;
   logic                mack_r;
   logic                mack_nxt;
   ctp_pkg::ctp_req_t   req_nxt;
   logic                req_go;
   logic                link_done;
   logic                byte_end;
   logic                addr_hit;
   logic                rx_state;

   assign byte_end = scl_fall && cnt_r == ctp_pkg::BITS_PER_BYTE;
   // no answer until initialisation has finished
   assign addr_hit = shift_r[7:1] == dev_addr && lk.init_done;
   assign rx_state = st_r == ctp_pkg::ST_ADDR || st_r == ctp_pkg::ST_REG ||
                     st_r == ctp_pkg::ST_WDATA;

   always_comb begin
      st_nxt    = st_r;
      after_nxt = after_r;
      cnt_nxt   = cnt_r;
      shift_nxt = shift_r;
      tx_nxt    = tx_r;
      ptr_nxt   = ptr_r;
      oe_nxt    = oe_r;
      mack_nxt  = mack_r;
      req_nxt   = req_r;
      req_go    = 1'b0;
      if (start_ev) begin
         st_nxt  = ctp_pkg::ST_ADDR;
         cnt_nxt = 4'h0;
         oe_nxt  = 1'b0;
      end else if (stop_ev) begin
         st_nxt = ctp_pkg::ST_IDLE;
         oe_nxt = 1'b0;
      end else begin
         if (rx_state && scl_rise && cnt_r != ctp_pkg::BITS_PER_BYTE) begin
            shift_nxt = {shift_r[6:0], lk.sda};
            cnt_nxt   = cnt_r + 4'h1;
         end
         case (st_r)
            ctp_pkg::ST_ADDR: begin
               if (byte_end) begin
                  cnt_nxt = 4'h0;
                  if (!addr_hit) begin
                     st_nxt = ctp_pkg::ST_IGNORE;
                  end else begin
                     oe_nxt = 1'b1;
                     st_nxt = ctp_pkg::ST_SACK;
                     if (shift_r[0]) begin
                        after_nxt = ctp_pkg::ST_RDATA;
                        req_nxt   = '{rd: 1'b1, ptr: ptr_r, data: 8'h00};
                        req_go    = 1'b1;
                        ptr_nxt   = ptr_r + 8'h01;
                     end else begin
                        after_nxt = ctp_pkg::ST_REG;
                     end
                  end
               end
            end
            ctp_pkg::ST_REG: begin
               if (byte_end) begin
                  cnt_nxt   = 4'h0;
                  ptr_nxt   = shift_r;
                  oe_nxt    = 1'b1;
                  st_nxt    = ctp_pkg::ST_SACK;
                  after_nxt = ctp_pkg::ST_WDATA;
               end
            end
            ctp_pkg::ST_WDATA: begin
               if (byte_end) begin
                  cnt_nxt   = 4'h0;
                  req_nxt   = '{rd: 1'b0, ptr: ptr_r, data: shift_r};
                  req_go    = 1'b1;
                  ptr_nxt   = ptr_r + 8'h01;
                  oe_nxt    = 1'b1;
                  st_nxt    = ctp_pkg::ST_SACK;
                  after_nxt = ctp_pkg::ST_WDATA;
               end
            end
            ctp_pkg::ST_SACK: begin
               if (scl_fall) begin
                  cnt_nxt = 4'h0;
                  st_nxt  = after_r;
                  if (after_r == ctp_pkg::ST_RDATA) begin
                     tx_nxt = rd_buf_r;
                     oe_nxt = !rd_buf_r[7];
                  end else begin
                     oe_nxt = 1'b0;
                  end
               end
            end
            ctp_pkg::ST_RDATA: begin
               if (scl_fall) begin
                  if (cnt_r == ctp_pkg::LAST_TX_BIT) begin
                     oe_nxt = 1'b0;
                     st_nxt = ctp_pkg::ST_MACK;
                  end else begin
                     tx_nxt  = {tx_r[6:0], 1'b0};
                     oe_nxt  = !tx_r[6];
                     cnt_nxt = cnt_r + 4'h1;
                  end
               end
            end
            ctp_pkg::ST_MACK: begin
               if (scl_rise) begin
                  mack_nxt = !lk.sda;
                  if (!lk.sda) begin
                     req_nxt = '{rd: 1'b1, ptr: ptr_r, data: 8'h00};
                     req_go  = 1'b1;
                     ptr_nxt = ptr_r + 8'h01;
                  end
               end
               if (scl_fall) begin
                  cnt_nxt = 4'h0;
                  if (mack_r) begin
                     tx_nxt = rd_buf_r;
                     oe_nxt = !rd_buf_r[7];
                     st_nxt = ctp_pkg::ST_RDATA;
                  end else begin
                     st_nxt = ctp_pkg::ST_IGNORE;
                  end
               end
            end
            ctp_pkg::ST_IDLE, ctp_pkg::ST_IGNORE: begin
               oe_nxt = 1'b0;
            end
            default: begin
               st_nxt = ctp_pkg::ST_IDLE;
               oe_nxt = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r    <= ctp_pkg::ST_IDLE;
         after_r <= ctp_pkg::ST_IDLE;
         cnt_r   <= 4'h0;
         shift_r <= 8'h00;
         tx_r    <= 8'h00;
         ptr_r   <= 8'h00;
         oe_r    <= 1'b0;
         mack_r  <= 1'b0;
         req_r   <= '0;
      end else if (lk.ce) begin
         st_r    <= st_nxt;
         after_r <= after_nxt;
         cnt_r   <= cnt_nxt;
         shift_r <= shift_nxt;
         tx_r    <= tx_nxt;
         ptr_r   <= ptr_nxt;
         oe_r    <= oe_nxt;
         mack_r  <= mack_nxt;
         req_r   <= req_nxt;
      end
   end

   // rd_data_r has settled before the acknowledge toggle arrives
   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_buf_r <= 8'h00;
      end else if (lk.ce && link_done && req_r.rd) begin
         rd_buf_r <= rd_data_r;
      end
   end

   // req_r is loaded on the go cycle, so the core reads it only after the toggle clears the two-stage synchroniser
   ctp_hs u_req_hs (
      .src_clk   (link_clk),
      .src_rst_b (rst_b),
      .src_ce    (lk.ce),
      .src_go    (req_go),
      .src_busy  (),
      .src_done  (link_done),
      .dst_clk   (clk),
      .dst_rst_b (rst_b),
      .dst_ce    (ce),
      .dst_take  (core_take)
   );

   // open drain: only ever pulled low
   assign sda_o  = 1'b0;
   assign sda_oe = oe_r;

endmodule

/* File: bench/ctp_port_monitor.sv */
`timescale 1ns/100ps
module ctp_port_monitor (
   input wire logic clk,             // core clock
   input wire logic rst_b,           // reset, low
   input wire logic link_clk,        // link clock
   input wire logic scl_i,           // bus clock
   input wire logic sda_i,           // bus data
   input wire logic sda_o,           // drive level
   input wire logic sda_oe,          // pulls low
   input wire logic addr_strap_low,  // strap 0
   input wire logic addr_strap_high, // strap 1
   input wire logic init_done,       // ready
   input wire logic standalone,      // strapped mode
   input wire logic mclk_enable,     // clock on
   input wire logic adc_clk_master   // ADC role
);
   a_quiet_init: assert property (@(posedge link_clk)
      disable iff (!rst_b) !init_done |-> !sda_oe)
      else $error("SDA pulled before ready");
   a_oe_scl_low: assert property (@(posedge link_clk)
      disable iff (!rst_b) $changed(sda_oe) |-> !scl_i)
      else $error("SDA moved with SCL high");
   a_drive_zero: assert property (@(posedge clk)
      disable iff (!rst_b) 1'b1 |-> sda_o == 1'b0)
      else $error("SDA driven high");
   a_init_len: assert property (@(posedge clk)
      disable iff (!rst_b) $rose(init_done) |-> !$past(init_done, 200))
      else $error("initialisation too short");
   a_mclk_off: assert property (@(posedge clk)
      disable iff (!rst_b) $rose(init_done) && !standalone |-> !mclk_enable)
      else $error("clock enabled by reset");
   a_std_straps: assert property (@(posedge clk)
      disable iff (!rst_b)
      $rose(standalone) |-> !addr_strap_low && !addr_strap_high && !scl_i)
      else $error("standalone without strap");
   a_std_config: assert property (@(posedge clk)
      disable iff (!rst_b)
      $rose(standalone) |-> mclk_enable && adc_clk_master == sda_i)
      else $error("standalone config wrong");
   a_mode_fixed: assert property (@(posedge clk)
      disable iff (!rst_b) 1'b1 |-> !$fell(standalone))
      else $error("mode left without reset");
endmodule

bind ctp_port ctp_port_monitor u_mon (.clk(clk), .rst_b(rst_b),
   .link_clk(link_clk), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
   .sda_oe(sda_oe), .addr_strap_low(addr_strap_low),
   .addr_strap_high(addr_strap_high), .init_done(init_done),
   .standalone(standalone), .mclk_enable(mclk_enable),
   .adc_clk_master(adc_clk_master));

/* File: bench/ctp_bus_master.sv */
`timescale 1ns/100ps
module ctp_bus_master (
   input  wire logic clk,    // paces the bus
   input  wire logic sda_oe, // device pulls SDA
   output logic      scl,    // bus clock
   output logic      sda     // wire level
);
   logic sda_m;
   // pull-up: a released wire reads high, never its last value
   assign sda = sda_m & ~sda_oe;
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   // 8 clk a step keeps both SCL phases well above the minimum
   task automatic to(input logic c, input logic d);
      repeat (8) @(posedge clk);
      scl <= c;
      sda_m <= d;
   endtask
   task automatic start();
      to(scl, 1'b1);
      to(1'b1, 1'b1);
      to(1'b1, 1'b0);
      to(1'b0, 1'b0);
   endtask
   task automatic stop();
      to(1'b0, 1'b0);
      to(1'b1, 1'b0);
      to(1'b1, 1'b1);
   endtask
   task automatic bit_io(input logic b, output logic r);
      to(1'b0, b);
      to(1'b1, b);
      repeat (8) @(posedge clk);
      r = sda;
      to(1'b0, b);
   endtask
   // ack_in low acknowledges a read byte
   task automatic xfer(input logic [7:0] tx, input logic ack_in,
                       output logic [7:0] rx, output logic ack);
      for (int i = 7; i >= 0; i--)
         bit_io(tx[i], rx[i]);
      bit_io(ack_in, ack);
   endtask
endmodule

/* File: bench/ctp_port_bench.sv */
`timescale 1ns/100ps
module ctp_port_bench;
   localparam logic [6:0] DEV = ctp_pkg::DEV_BASE_ADDR | 7'h01;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst_b = 1'b0;
   logic s_lo = 1'b1;
   logic s_hi = 1'b0;
   logic scl, sda, sda_oe, init_done, standalone, mclk_en, adc_m;
   logic [ctp_pkg::REG_COUNT-1:0][7:0] regs;
   int err_count = 0;
   int n_compared = 0;
   always #5 clk = ~clk;
   initial begin
      #1.3;
      forever #3 link_clk = ~link_clk;
   end
   ctp_port dut (.clk(clk), .rst_b(rst_b), .ce(1'b1), .link_clk(link_clk),
      .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
      .addr_strap_low(s_lo), .addr_strap_high(s_hi), .pll_locked(1'b1),
      .init_done(init_done), .standalone(standalone),
      .mclk_enable(mclk_en), .adc_clk_master(adc_m), .ctrl_regs(regs));
   ctp_bus_master u_mst (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
   ////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      if (err_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      n_compared++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   task automatic boot(input logic lo, input logic hi, input logic d);
      int n;
      rst_b <= 1'b0;
      s_lo <= lo;
      s_hi <= hi;
      u_mst.scl <= lo | hi;
      u_mst.sda_m <= d;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      repeat (12) @(posedge clk);
      u_mst.scl <= 1'b1;
      u_mst.sda_m <= 1'b1;
      for (n = 0; n < 400 && init_done !== 1'b1; n++)
         @(posedge clk);
      chk(n > 240 && n < 300, "init length");
      if (n == 400)
         close_out();
      repeat (5) @(posedge clk);
   endtask
   task automatic put(input logic [7:0] b, input logic ack_exp);
      logic [7:0] rx;
      logic ak;
      u_mst.xfer(b, 1'b1, rx, ak);
      chk(ak === ~ack_exp, "acknowledge");
   endtask
   task automatic get(input logic [7:0] exp, input logic last);
      logic [7:0] rx;
      logic ak;
      u_mst.xfer(8'hFF, last, rx, ak);
      chk(rx === exp, "read data");
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic s_standalone(input logic d);
      boot(1'b0, 1'b0, d);
      chk(standalone === 1'b1, "standalone");
      chk(mclk_en === 1'b1, "forced clock");
      chk(adc_m === d, "adc role");
      chk(regs[6] === 8'h00, "default");
   endtask
   task automatic s_write();
      u_mst.start();
      put({DEV, 1'b0}, 1'b1);
      put(8'h06, 1'b1);
      put(8'h5A, 1'b1);
      put(8'hC3, 1'b1);
      u_mst.stop();
      u_mst.start();
      put({DEV, 1'b0}, 1'b1);
      put(8'h00, 1'b1);
      put(8'h01, 1'b1);
      u_mst.stop();
      chk(regs[6] === 8'h5A, "single byte");
      chk(regs[7] === 8'hC3, "burst byte");
      chk(mclk_en === 1'b1, "clock enable");
   endtask
   task automatic s_read();
      u_mst.start();
      put({DEV, 1'b0}, 1'b1);
      put(8'h06, 1'b1);
      u_mst.start();
      put({DEV, 1'b1}, 1'b1);
      get(8'h5A, 1'b0);
      get(8'hC3, 1'b1);
      u_mst.stop();
   endtask
   task automatic s_foreign();
      u_mst.start();
      put({ctp_pkg::DEV_BASE_ADDR, 1'b0}, 1'b0);
      put(8'h06, 1'b0);
      put(8'h00, 1'b0);
      u_mst.stop();
      chk(regs[6] === 8'h5A, "ignored write");
   endtask
   initial begin
      s_standalone(1'b0);
      s_standalone(1'b1);
      boot(1'b1, 1'b0, 1'b1);
      chk(standalone === 1'b0 && mclk_en === 1'b0, "reset");
      s_write();
      s_read();
      s_foreign();
      close_out();
   end
endmodule
